// >>> rtl/scp_pkg.sv
// Package for the system clock and power mode controller.
// Assumes a single 125 MHz clock domain with an Avalon-MM register slave.
package scp_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] SCP_ADDR_SYSTEM_MODE_CONTROL = 4'h0;
  localparam logic [3:0] SCP_ADDR_CTRL = 4'h4;

  // Reset values of the writable fields
  localparam logic [2:0] SCP_CKS_RST = 3'h0;
  localparam logic SCP_IDLE_ON_HALT_ENABLE_RST = 1'b1;
  localparam logic SCP_HIGH_CLOCK_SELECT_BIT_RST = 1'b1;
  localparam logic [1:0] SCP_RCSEL_RST = 2'h0;

  // Divider select codes
  localparam logic [2:0] SCP_CKS_SUB1 = 3'h1;
  localparam logic [2:0] SCP_CKS_D64 = 3'h2;
  localparam logic [2:0] SCP_CKS_D32 = 3'h3;
  localparam logic [2:0] SCP_CKS_D16 = 3'h4;
  localparam logic [2:0] SCP_CKS_D8 = 3'h5;
  localparam logic [2:0] SCP_CKS_D4 = 3'h6;
  localparam logic [2:0] SCP_CKS_D2 = 3'h7;

  // Bit positions in the read words
  localparam int SCP_SYSTEM_MODE_CONTROL_RSV_BIT = 4;
  localparam int SCP_CTRL_RSV_BIT = 6;

  // Oscillator input lanes
  localparam int SCP_OSC_INTERNAL_HIGH_SPEED_RC = 0;
  localparam int SCP_OSC_SUB = 1;

  // Settling counts in oscillator cycles
  localparam logic [4:0] SCP_HTO_CYCLES = 5'h0f;
  localparam logic [10:0] SCP_LTO_LXT_CYCLES = 11'h400;
  localparam logic [10:0] SCP_LTO_INTERNAL_LOW_SPEED_RC_CYCLES = 11'h001;

  typedef enum logic [3:0] {
    SCP_RUN   = 4'h1,
    SCP_SLEEP = 4'h2,
    SCP_OSCILLATOR_OFF_IDLE_MODE = 4'h4,
    SCP_OSCILLATOR_ON_IDLE_MODE = 4'h8
  } scp_state_t;

  typedef struct packed {
    logic [2:0] divider_select_field;
    logic idle_on_halt_enable;
    logic high_clock_select_bit;
  } scp_system_mode_control_t;

  typedef struct packed {
    logic system_clock_in_idle_enable;
    logic [1:0] rc_frequency_select_field;
    logic crystal_drive_mode_bit;
    logic voltage_reset_flag;
    logic spare_bit;
    logic watchdog_register_reset_flag;
  } scp_ctrl_t;

endpackage

// >>> rtl/scp_ctrl.sv
// System clock selection, oscillator enables and halt power modes.
// Assumes oscillator levels arrive unsynchronised on pins, halt and wake
// pulses come from logic on clk_i, and the sub clock source strap is static.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - Divider field picks sub or divided clock
// - High-clock bit picks undivided high clock
// - Leaving high clock for sub stops it
// - Low-speed ready after oscillator settles
// - High-speed ready after 15 edges, low off
// - Unimplemented bits always read zero
// - Halt with idle off enters sleep
// - Halt, idle, clock-in-idle enters oscillator_on_idle_mode
// - Halt, idle, no clock enters oscillator_off_idle_mode
// - Power modes keep all register state
// - Sleep clears and stops the watchdog
// - Oscillator_off_idle_mode clears watchdog, keeps it counting
// - Halt sets power-down, clears timeout flag
// - RC frequency field selects 8/12/16 MHz
// - Control bit 3 sets crystal drive
// - Control bit 1 is plain storage
// - Sub selected stops high clock and taps
// - Oscillator_on_idle_mode keeps clocks, watchdog cleared, counting
module scp_ctrl
  import scp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic internal_high_speed_rc_osc_i,
  input wire logic sub_osc_i,
  input wire logic sub_is_lxt_i,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic wdt_timeout_i,
  input wire logic wdt_clear_instr_i,
  input wire logic voltage_reset_event_i,
  input wire logic watchdog_register_reset_event_i,
  output logic sys_clk_o,
  output logic internal_high_speed_rc_en_o,
  output logic sub_en_o,
  output logic [1:0] rc_freq_sel_o,
  output logic crystal_low_power_o,
  output logic cpu_run_o,
  output logic wdt_clear_o,
  output logic wdt_run_o,
  output logic power_down_status_flag_o,
  output logic watchdog_timeout_status_flag_o
);

  scp_system_mode_control_t system_mode_control_ff;
  scp_ctrl_t ctrl_ff;
  scp_state_t state_ff;
  scp_state_t nxt_state;
  logic [1:0] s1_ff, s2_ff, s3_ff, osc_lvl_ff, osc_prev_ff;
  logic internal_high_speed_rc_rise, sub_rise;
  logic [5:0] div_ff;
  logic [4:0] hto_cnt_ff;
  logic [10:0] lto_cnt_ff;
  logic [10:0] lto_target;
  logic hto_ff, lto_ff;
  logic lxt_sel_ff, strap_done_ff;
  logic [3:0] want_key, act_key_ff;
  logic want_lvl, act_lvl, want_sub, act_sub;
  logic sys_clk_ff, internal_high_speed_rc_en_ff, sub_en_ff;
  logic cpu_run_ff, wdt_clear_ff, wdt_run_ff, pdf_ff, to_ff;
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic req, bus_wr, halt_take;
  logic [7:0] system_mode_control_rd, ctrl_rd;

  // Source level for a selection key {high-clock bit, divider field}
  function automatic logic scp_src(input logic [3:0] key, input logic fh,
                                   input logic fsub, input logic [5:0] div);
    logic lvl;
    lvl = fsub;
    if (key[3]) begin
      lvl = fh;
    end else begin
      case (key[2:0])
        SCP_CKS_D64: lvl = div[5];
        SCP_CKS_D32: lvl = div[4];
        SCP_CKS_D16: lvl = div[3];
        SCP_CKS_D8: lvl = div[2];
        SCP_CKS_D4: lvl = div[1];
        SCP_CKS_D2: lvl = div[0];
        default: lvl = fsub;
      endcase
    end
    return lvl;
  endfunction

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Oscillator pins: three stages, level taken once stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
      s3_ff <= 2'h0;
      osc_lvl_ff <= 2'h0;
      osc_prev_ff <= 2'h0;
    end else begin
      s1_ff <= {sub_osc_i, internal_high_speed_rc_osc_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      osc_lvl_ff <= (s2_ff & s3_ff) | (osc_lvl_ff & (s2_ff | s3_ff));
      osc_prev_ff <= osc_lvl_ff;
    end
  end

  assign internal_high_speed_rc_rise = osc_lvl_ff[SCP_OSC_INTERNAL_HIGH_SPEED_RC] & ~osc_prev_ff[SCP_OSC_INTERNAL_HIGH_SPEED_RC];
  assign sub_rise = osc_lvl_ff[SCP_OSC_SUB] & ~osc_prev_ff[SCP_OSC_SUB];

  // Sub clock source strap caught once after reset release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lxt_sel_ff <= 1'b0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      lxt_sel_ff <= sub_is_lxt_i;
      strap_done_ff <= 1'b1;
    end
  end

  // High clock divider taps; frozen at zero while the oscillator is off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= 6'h00;
    end else if (!internal_high_speed_rc_en_ff) begin
      div_ff <= 6'h00;
    end else if (internal_high_speed_rc_rise) begin
      div_ff <= div_ff + 6'h01;
    end
  end

  assign want_key = {system_mode_control_ff.high_clock_select_bit, system_mode_control_ff.divider_select_field};
  assign want_lvl = scp_src(want_key, osc_lvl_ff[SCP_OSC_INTERNAL_HIGH_SPEED_RC], osc_lvl_ff[SCP_OSC_SUB],
                            div_ff);
  assign act_lvl = scp_src(act_key_ff, osc_lvl_ff[SCP_OSC_INTERNAL_HIGH_SPEED_RC], osc_lvl_ff[SCP_OSC_SUB],
                           div_ff);
  assign want_sub = !want_key[3] && (want_key[2:0] <= SCP_CKS_SUB1);
  assign act_sub = !act_key_ff[3] && (act_key_ff[2:0] <= SCP_CKS_SUB1);

  // Selection changes only while output and new source are both low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_key_ff <= {SCP_HIGH_CLOCK_SELECT_BIT_RST, SCP_CKS_RST};
    end else if (want_key != act_key_ff && !sys_clk_ff && !want_lvl) begin
      act_key_ff <= want_key;
    end
  end

  // Clock output follows the active source; when stopped it falls with it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_clk_ff <= 1'b0;
    end else if (want_key != act_key_ff || state_ff == SCP_SLEEP
                 || state_ff == SCP_OSCILLATOR_OFF_IDLE_MODE) begin
      sys_clk_ff <= sys_clk_ff & act_lvl;
    end else begin
      sys_clk_ff <= act_lvl;
    end
  end

  // Oscillator enables
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      internal_high_speed_rc_en_ff <= 1'b1;
      sub_en_ff <= 1'b1;
    end else begin
      internal_high_speed_rc_en_ff <= !(nxt_state == SCP_SLEEP || nxt_state == SCP_OSCILLATOR_OFF_IDLE_MODE)
                    && !(want_sub && act_sub);
      sub_en_ff <= nxt_state != SCP_SLEEP;
    end
  end

  // High-speed ready: counts oscillator edges after each start
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hto_cnt_ff <= 5'h00;
      hto_ff <= 1'b0;
    end else if (!internal_high_speed_rc_en_ff) begin
      hto_cnt_ff <= 5'h00;
      hto_ff <= 1'b0;
    end else begin
      if (internal_high_speed_rc_rise && hto_cnt_ff < SCP_HTO_CYCLES) begin
        hto_cnt_ff <= hto_cnt_ff + 5'h01;
      end
      hto_ff <= hto_cnt_ff == SCP_HTO_CYCLES;
    end
  end

  assign lto_target = lxt_sel_ff ? SCP_LTO_LXT_CYCLES : SCP_LTO_INTERNAL_LOW_SPEED_RC_CYCLES;

  // Low-speed ready: held low in sleep, rises after the settling count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lto_cnt_ff <= 11'h000;
      lto_ff <= 1'b0;
    end else if (!sub_en_ff || !strap_done_ff) begin
      lto_cnt_ff <= 11'h000;
      lto_ff <= 1'b0;
    end else begin
      if (sub_rise && lto_cnt_ff < lto_target) begin
        lto_cnt_ff <= lto_cnt_ff + 11'h001;
      end
      lto_ff <= lto_cnt_ff >= lto_target;
    end
  end

  // Power mode sequencing
  assign halt_take = halt_i && state_ff == SCP_RUN;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SCP_RUN: begin
        if (halt_i) begin
          if (!system_mode_control_ff.idle_on_halt_enable) begin
            nxt_state = SCP_SLEEP;
          end else if (ctrl_ff.system_clock_in_idle_enable) begin
            nxt_state = SCP_OSCILLATOR_ON_IDLE_MODE;
          end else begin
            nxt_state = SCP_OSCILLATOR_OFF_IDLE_MODE;
          end
        end
      end
      SCP_SLEEP, SCP_OSCILLATOR_OFF_IDLE_MODE, SCP_OSCILLATOR_ON_IDLE_MODE: begin
        if (wake_i) begin
          nxt_state = SCP_RUN;
        end
      end
      default: nxt_state = SCP_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= SCP_RUN;
      cpu_run_ff <= 1'b1;
      wdt_run_ff <= 1'b1;
      wdt_clear_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cpu_run_ff <= nxt_state == SCP_RUN;
      wdt_run_ff <= nxt_state != SCP_SLEEP;
      wdt_clear_ff <= halt_take;
    end
  end

  // Status flags: the hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pdf_ff <= 1'b0;
      to_ff <= 1'b0;
    end else begin
      pdf_ff <= halt_take || (pdf_ff && !wdt_clear_instr_i);
      to_ff <= wdt_timeout_i || (to_ff && !halt_take && !wdt_clear_instr_i);
    end
  end

  // Avalon-MM slave: one wait cycle, then the access completes
  assign req = avs_read_i || avs_write_i;
  assign bus_wr = avs_write_i && !waitreq_ff && avs_byteenable_i[0];
  assign system_mode_control_rd = {system_mode_control_ff.divider_select_field, 1'b0, lto_ff, hto_ff,
                    system_mode_control_ff.idle_on_halt_enable, system_mode_control_ff.high_clock_select_bit};
  assign ctrl_rd = {ctrl_ff.system_clock_in_idle_enable, 1'b0,
                    ctrl_ff.rc_frequency_select_field, ctrl_ff.crystal_drive_mode_bit,
                    ctrl_ff.voltage_reset_flag, ctrl_ff.spare_bit,
                    ctrl_ff.watchdog_register_reset_flag};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      waitreq_ff <= !(req && waitreq_ff);
      if (avs_read_i && waitreq_ff) begin
        case (avs_address_i)
          SCP_ADDR_SYSTEM_MODE_CONTROL: rdata_ff <= {24'h00_0000, system_mode_control_rd};
          SCP_ADDR_CTRL: rdata_ff <= {24'h00_0000, ctrl_rd};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registers change only by bus writes or flag events, never by mode entry
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      system_mode_control_ff <= '{SCP_CKS_RST, SCP_IDLE_ON_HALT_ENABLE_RST, SCP_HIGH_CLOCK_SELECT_BIT_RST};
    end else if (bus_wr && avs_address_i == SCP_ADDR_SYSTEM_MODE_CONTROL) begin
      system_mode_control_ff.divider_select_field <= avs_writedata_i[7:5];
      system_mode_control_ff.idle_on_halt_enable <= avs_writedata_i[1];
      system_mode_control_ff.high_clock_select_bit <= avs_writedata_i[0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff <= '{1'b0, SCP_RCSEL_RST, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      if (bus_wr && avs_address_i == SCP_ADDR_CTRL) begin
        ctrl_ff.system_clock_in_idle_enable <= avs_writedata_i[7];
        ctrl_ff.rc_frequency_select_field <= avs_writedata_i[5:4];
        ctrl_ff.crystal_drive_mode_bit <= avs_writedata_i[3];
        ctrl_ff.spare_bit <= avs_writedata_i[1];
        ctrl_ff.voltage_reset_flag <= avs_writedata_i[2] | voltage_reset_event_i;
        ctrl_ff.watchdog_register_reset_flag <= avs_writedata_i[0]
                                                | watchdog_register_reset_event_i;
      end else begin
        ctrl_ff.voltage_reset_flag <= ctrl_ff.voltage_reset_flag | voltage_reset_event_i;
        ctrl_ff.watchdog_register_reset_flag <= ctrl_ff.watchdog_register_reset_flag
                                                | watchdog_register_reset_event_i;
      end
    end
  end

  // RC code 11 is the same 8 MHz setting as 00
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rc_freq_sel_o <= SCP_RCSEL_RST;
    end else if (ctrl_ff.rc_frequency_select_field == 2'h3) begin
      rc_freq_sel_o <= 2'h0;
    end else begin
      rc_freq_sel_o <= ctrl_ff.rc_frequency_select_field;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crystal_low_power_o <= 1'b0;
    end else begin
      crystal_low_power_o <= ctrl_ff.crystal_drive_mode_bit;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = waitreq_ff;
  assign sys_clk_o = sys_clk_ff;
  assign internal_high_speed_rc_en_o = internal_high_speed_rc_en_ff;
  assign sub_en_o = sub_en_ff;
  assign cpu_run_o = cpu_run_ff;
  assign wdt_clear_o = wdt_clear_ff;
  assign wdt_run_o = wdt_run_ff;
  assign power_down_status_flag_o = pdf_ff;
  assign watchdog_timeout_status_flag_o = to_ff;

  sequence s_halt_run;
    state_ff == SCP_RUN && halt_i;
  endsequence

  sequence s_cleared_then_run;
    wdt_clear_o && wdt_run_o ##1 wdt_run_o;
  endsequence

  halt_sleep_a: assert property (s_halt_run and !system_mode_control_ff.idle_on_halt_enable |=>
    state_ff == SCP_SLEEP && !sub_en_o && !cpu_run_o)
    else $error("halt with idle off did not enter sleep");
  halt_idle_one_a: assert property (s_halt_run and system_mode_control_ff.idle_on_halt_enable
    && ctrl_ff.system_clock_in_idle_enable |=> state_ff == SCP_OSCILLATOR_ON_IDLE_MODE && sub_en_o)
    else $error("halt did not enter oscillator_on_idle_mode");
  halt_idle_zero_a: assert property (s_halt_run and system_mode_control_ff.idle_on_halt_enable
    && !ctrl_ff.system_clock_in_idle_enable |=> state_ff == SCP_OSCILLATOR_OFF_IDLE_MODE && sub_en_o
    && !internal_high_speed_rc_en_o)
    else $error("halt did not enter oscillator_off_idle_mode");
  wdt_sleep_a: assert property (s_halt_run and !system_mode_control_ff.idle_on_halt_enable |=>
    wdt_clear_o && !wdt_run_o)
    else $error("watchdog not cleared and stopped in sleep");
  wdt_idle_a: assert property (s_halt_run and system_mode_control_ff.idle_on_halt_enable && !wake_i
    |=> s_cleared_then_run)
    else $error("watchdog not cleared and counting in idle");
  pdf_set_a: assert property (s_halt_run and !wdt_timeout_i |=>
    power_down_status_flag_o && !watchdog_timeout_status_flag_o)
    else $error("halt flags wrong");
  hto_low_a: assert property (!internal_high_speed_rc_en_o |=> !hto_ff)
    else $error("high ready flag high while oscillator off");
  rsv_zero_a: assert property (!waitreq_ff && avs_read_i |->
    (avs_address_i != SCP_ADDR_SYSTEM_MODE_CONTROL || !avs_readdata_o[SCP_SYSTEM_MODE_CONTROL_RSV_BIT])
    && (avs_address_i != SCP_ADDR_CTRL || !avs_readdata_o[SCP_CTRL_RSV_BIT]))
    else $error("unimplemented bit read as one");
  internal_high_speed_rc_off_a: assert property (state_ff == SCP_RUN && want_sub && act_sub && !halt_i
    |=> !internal_high_speed_rc_en_o)
    else $error("high oscillator still on with sub clock selected");
  no_glitch_a: assert property ($rose(sys_clk_o) |-> $past(act_lvl)
    && $past(want_key) == $past(act_key_ff))
    else $error("system clock rose outside the active source");

endmodule // scp_ctrl

// >>> verif/testbench.sv
// Self-checking bench for scp_ctrl: register bus, clock selection, halt modes.
// Assumes the bench plays the CPU, the bus master and both oscillators.
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import scp_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic internal_high_speed_rc_osc_i = 1'b0;
  logic sub_osc_i = 1'b0;
  logic sub_is_lxt_i = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [31:0] avs_readdata_o;
  logic [1:0] rc_freq_sel_o;
  logic avs_waitrequest_o, sys_clk_o, internal_high_speed_rc_en_o, sub_en_o, crystal_low_power_o;
  logic cpu_run_o, wdt_clear_o, wdt_run_o, power_down_status_flag_o;
  logic watchdog_timeout_status_flag_o;
  int fail_count = 0;
  int cmp_count = 0;
  int hcnt = 0;
  int scnt = 0;
  int edges, e, t0;
  logic [31:0] seed = 32'he4c3;
  logic [31:0] rd;
  logic [7:0] w;
  logic idle, fsys;

  scp_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .internal_high_speed_rc_osc_i(internal_high_speed_rc_osc_i), .sub_osc_i(sub_osc_i),
    .sub_is_lxt_i(sub_is_lxt_i), .halt_i(ev[0]), .wake_i(ev[1]), .wdt_timeout_i(ev[2]),
    .wdt_clear_instr_i(ev[3]), .voltage_reset_event_i(ev[4]),
    .watchdog_register_reset_event_i(ev[5]), .sys_clk_o(sys_clk_o), .internal_high_speed_rc_en_o(internal_high_speed_rc_en_o),
    .sub_en_o(sub_en_o), .rc_freq_sel_o(rc_freq_sel_o),
    .crystal_low_power_o(crystal_low_power_o), .cpu_run_o(cpu_run_o),
    .wdt_clear_o(wdt_clear_o), .wdt_run_o(wdt_run_o),
    .power_down_status_flag_o(power_down_status_flag_o),
    .watchdog_timeout_status_flag_o(watchdog_timeout_status_flag_o));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Oscillators only run while enabled: high RC period 6 clocks, sub 40
  always @(posedge clk_i) begin
    hcnt <= (hcnt == 2) ? 0 : hcnt + 1;
    scnt <= (scnt == 19) ? 0 : scnt + 1;
    if (!internal_high_speed_rc_en_o) internal_high_speed_rc_osc_i <= 1'b0;
    else if (hcnt == 2) internal_high_speed_rc_osc_i <= ~internal_high_speed_rc_osc_i;
    if (!sub_en_o) sub_osc_i <= 1'b0;
    else if (scnt == 19) sub_osc_i <= ~sub_osc_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic int period(input logic hl, input logic [2:0] cks);
    if (hl) return 6;
    if (cks < 3'h2) return 40;
    return 6 << (8 - cks);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      fail_count++;
      report_and_stop();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // Polls a mode register bit until it is set, within a bounded count of reads
  task automatic poll(input int b, input int lim);
    int n;
    n = 0;
    do begin
      bus(1'b0, SCP_ADDR_SYSTEM_MODE_CONTROL, 8'h00, 4'h1);
      n++;
    end while (rd[b] !== 1'b1 && n < lim);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
  endtask

  task automatic count_edges(input int n);
    logic p;
    p = sys_clk_o;
    edges = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (sys_clk_o === 1'b1 && p === 1'b0) edges++;
      p = sys_clk_o;
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    `CHK({internal_high_speed_rc_en_o, sub_en_o, cpu_run_o, wdt_run_o}, 4'hf);
    bus(1'b0, SCP_ADDR_SYSTEM_MODE_CONTROL, 8'h00, 4'h1);
    `CHK(rd & 32'hf3, 32'h03);
    bus(1'b0, SCP_ADDR_CTRL, 8'h00, 4'h1);
    `CHK(rd, 32'h00);
    poll(2, 60);
    `CHK(rd[2], 1'b1);
    poll(3, 60);
    `CHK(rd[3], 1'b1);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      w = (i == 0) ? 8'hfa : seed[7:0] & 8'hfa;
      bus(1'b1, SCP_ADDR_CTRL, w, 4'h1);
      bus(1'b0, SCP_ADDR_CTRL, 8'h00, 4'h1);
      `CHK(rd, {24'h0, w & 8'hba});
      `CHK(rc_freq_sel_o, (w[5:4] == 2'h3) ? 2'h0 : w[5:4]);
      `CHK(crystal_low_power_o, w[3]);
      seed = xs(seed);
      bus(1'b1, SCP_ADDR_SYSTEM_MODE_CONTROL, seed[7:0], 4'h1);
      bus(1'b0, SCP_ADDR_SYSTEM_MODE_CONTROL, 8'h00, 4'h1);
      `CHK(rd & 32'hf3, {24'h0, seed[7:0] & 8'he3});
    end
    bus(1'b1, SCP_ADDR_CTRL, ~w, 4'h0);
    bus(1'b1, 4'h8, 8'hff, 4'h1);
    bus(1'b0, SCP_ADDR_CTRL, 8'h00, 4'h1);
    `CHK(rd, {24'h0, w & 8'hba});
    bus(1'b0, 4'h8, 8'h00, 4'h1);
    `CHK(rd, 32'h0);
    pulse(4);
    pulse(5);
    bus(1'b0, SCP_ADDR_CTRL, 8'h00, 4'h1);
    `CHK(rd[2:0] & 3'h5, 3'h5);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      w = (k == 0) ? 8'h03 : {(k == 7) ? 3'h0 : 3'(8 - k), 5'h02};
      bus(1'b1, SCP_ADDR_SYSTEM_MODE_CONTROL, w, 4'h1);
      repeat (400) @(posedge clk_i);
      count_edges(768);
      e = 768 / period(w[0], w[7:5]);
      `CHK(edges >= e - 1 && edges <= e + 1, 1'b1);
      if (k == 7) `CHK(internal_high_speed_rc_en_o, 1'b0);
    end
    poll(3, 60);
    `CHK(rd[3], 1'b1);
    bus(1'b1, SCP_ADDR_SYSTEM_MODE_CONTROL, 8'h03, 4'h1);
    poll(2, 60);
    `CHK(rd[2], 1'b1);
    $display("test clock select done");
    for (int m = 0; m < 3; m++) begin
      idle = (m != 0);
      fsys = (m == 2);
      bus(1'b1, SCP_ADDR_CTRL, {fsys, 7'h00}, 4'h1);
      bus(1'b1, SCP_ADDR_SYSTEM_MODE_CONTROL, {6'h00, idle, 1'b1}, 4'h1);
      pulse(2);
      pulse(0);
      #1;
      `CHK({cpu_run_o, wdt_clear_o, power_down_status_flag_o}, 3'b011);
      `CHK(watchdog_timeout_status_flag_o, 1'b0);
      `CHK({wdt_run_o, sub_en_o}, {idle, idle});
      repeat (8) @(posedge clk_i);
      `CHK({internal_high_speed_rc_en_o, wdt_clear_o}, {fsys, 1'b0});
      count_edges(60);
      `CHK(edges > 0, fsys);
      bus(1'b0, SCP_ADDR_SYSTEM_MODE_CONTROL, 8'h00, 4'h1);
      `CHK(rd & 32'hf3, {6'h00, idle, 1'b1});
      `CHK({rd[3], rd[2]}, {idle, fsys});
      `CHK(cpu_run_o, 1'b0);
      pulse(1);
      #1;
      `CHK(cpu_run_o, 1'b1);
      poll(2, 60);
      `CHK(rd[2], 1'b1);
      poll(3, 60);
      `CHK(rd[3], 1'b1);
      pulse(3);
      #1;
      `CHK(power_down_status_flag_o, 1'b0);
    end
    $display("test power modes done");
    resetn_i <= 1'b0;
    sub_is_lxt_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    t0 = $time;
    poll(3, 20000);
    `CHK(rd[3], 1'b1);
    `CHK(($time - t0) / 8 >= 1020 * 40, 1'b1);
    $display("test crystal settle done");
    report_and_stop();
  end
endmodule // testbench
